// ==== shared/srl_pkg.sv ====
// Shared constants, types and helper functions of the serial register loop block.
// =====================================================================
// Functional notes
// [R1] First word stores at control byte address.
// [R2] Held chip select continues transfers, no control byte.
// [R3] Serial output floats during every write.
// [R4] Serial input sampled on rising clock edges.
// [R5] Non-writable target: no change, pointer stalls.
// [R6] Host restarts after stall at writable address.
// [R7] One control byte; loop until select rises.
// [R8] Pointer advances in set, wraps after last.
// [R9] Read loop field picks static/group/type/full.
// [R10] Input ignored after control byte on reads.
// [R11] Idle-low clock: old MSB, then new at ready.
// [R12] Idle-high clock: output holds last LSB.
// [R13] Write loop bit: static or type set.
// [R14] Key not unlocked: only key register writable.
// [R15] Phase write or setting change restarts converters.
// [R16] Restart clears results; conversion resumes alone.
// [R17] Ready pulse low for half modulator period.
// [R18] First pulse after settle plus delay; periodic.
// [R19] Idle ready pin floats or drives high.
// [R20] Ready pulses ignore chip select entirely.
// [R21] Hardware reset low silences ready pin.
// [R22] Checksum flag latches ready pin low.
// [R23] Chip select rise aborts, interface returns idle.
// [R24] Control byte: identifier, address, direction; match only.
// [R25] Low control bit: one reads, zero writes.
// [R26] Host reads after output update delay.
package srl_pkg;

  // =====================================================================
  // Widths and counts
  localparam int DATA_W = 24;
  localparam int PH_DELAY_W = 12;
  localparam logic [4:0] WORD_LAST = 5'h17;
  localparam logic [4:0] CTRL_LAST = 5'h07;
  localparam logic [1:0] DEV_ID_DEF = 2'h1;

  // =====================================================================
  // Register addresses
  localparam logic [4:0] ADDR_FIRST = 5'h00;
  localparam logic [4:0] ADDR_RES_LAST = 5'h07;
  localparam logic [4:0] ADDR_CFG_FIRST = 5'h08;
  localparam logic [4:0] ADDR_PHASE0 = 5'h08;
  localparam logic [4:0] ADDR_PHASE1 = 5'h09;
  localparam logic [4:0] ADDR_STATUS = 5'h0A;
  localparam logic [4:0] ADDR_CONFIG = 5'h0B;
  localparam logic [4:0] ADDR_CHAN = 5'h0C;
  localparam logic [4:0] ADDR_KEY = 5'h1F;

  // =====================================================================
  // Field positions
  localparam int ST_READ_LSB = 22;
  localparam int ST_WRITE_BIT = 21;
  localparam int ST_FLOAT_BIT = 20;
  localparam int CF_OSR_LSB = 13;
  localparam int CF_PRE_LSB = 16;
  localparam int CF_EXTCLK_BIT = 6;
  localparam int CF_EXTREF_BIT = 7;
  localparam int CH_SOFT_LSB = 8;
  localparam int CH_SHDN_LSB = 0;
  localparam int KEY_LSB = 0;
  localparam int PH_DELAY_LSB = 0;

  // =====================================================================
  // Reset values
  localparam logic [DATA_W-1:0] STATUS_RST = 24'hA0_0000;
  localparam logic [DATA_W-1:0] KEY_RST = 24'h00_00A5;
  localparam logic [7:0] KEY_UNLOCK = 8'hA5;

  typedef logic [DATA_W-1:0] srl_word_t;

  typedef enum logic [1:0] {
    SRL_LOOP_STATIC = 2'b00,
    SRL_LOOP_GROUP = 2'b01,
    SRL_LOOP_TYPE = 2'b10,
    SRL_LOOP_FULL = 2'b11
  } srl_loop_e;

  typedef enum logic [2:0] {
    SRL_PH_IDLE = 3'b000,
    SRL_PH_CTRL = 3'b001,
    SRL_PH_WRITE = 3'b010,
    SRL_PH_READ = 3'b011,
    SRL_PH_HOLD = 3'b100
  } srl_phase_e;

  // =====================================================================
  // Address set arithmetic
  function automatic logic [4:0] set_first(input logic [4:0] a, input srl_loop_e m);
    case (m)
      SRL_LOOP_STATIC: set_first = a;
      SRL_LOOP_GROUP: set_first = (a <= ADDR_RES_LAST) ? {a[4:1], 1'b0} : ADDR_CFG_FIRST;
      SRL_LOOP_TYPE: set_first = (a <= ADDR_RES_LAST) ? ADDR_FIRST : ADDR_CFG_FIRST;
      default: set_first = ADDR_FIRST;
    endcase
  endfunction

  function automatic logic [4:0] set_last(input logic [4:0] a, input srl_loop_e m);
    case (m)
      SRL_LOOP_STATIC: set_last = a;
      SRL_LOOP_GROUP: set_last = (a <= ADDR_RES_LAST) ? {a[4:1], 1'b1} : ADDR_KEY;
      SRL_LOOP_TYPE: set_last = (a <= ADDR_RES_LAST) ? ADDR_RES_LAST : ADDR_KEY;
      default: set_last = ADDR_KEY;
    endcase
  endfunction

  function automatic logic [4:0] next_ptr(input logic [4:0] a, input srl_loop_e m);
    next_ptr = (a == set_last(a, m)) ? set_first(a, m) : 5'(a + 5'h01);
  endfunction

  // Result addresses are never writable; a locked map leaves only the key register open.
  function automatic logic may_write(input logic [4:0] a, input logic locked);
    may_write = (a >= ADDR_CFG_FIRST) && (!locked || a == ADDR_KEY);
  endfunction

endpackage

// ==== shared/srl_ready_if.sv ====
// Signals between the serial port logic and the sample-ready pulse generator.
`timescale 1ns/100ps
interface srl_ready_if;
  logic restart;
  logic float_sel;
  logic [srl_pkg::PH_DELAY_W-1:0] phase_delay;
  logic crc_flag;
  logic hw_active;
  logic ready_start;
  logic ready_o;
  logic ready_oe;
  modport ctl (
    output restart, float_sel, phase_delay, crc_flag, hw_active,
    input ready_start, ready_o, ready_oe
  );
  modport gen (
    input restart, float_sel, phase_delay, crc_flag, hw_active,
    output ready_start, ready_o, ready_oe
  );
endinterface // srl_ready_if

// ==== rtl/srl_ready_gen.sv ====
// Sample-ready pulse generator, timed from the modulator clock.
`timescale 1ns/100ps
module srl_ready_gen #(
  parameter int MOD_DIV = 4,
  parameter int RATE_DIV = 256,
  parameter int SETTLE = 1024
) (
  input wire logic clk,
  input wire logic rst,
  srl_ready_if.gen ifc
);
  import srl_pkg::*;

  if (MOD_DIV < 2 || MOD_DIV % 2 != 0 || RATE_DIV < 2 || SETTLE + 4096 > 65535) begin : g_bad_param
    $error("srl_ready_gen: unsupported divider or settle value");
  end

  localparam logic [15:0] DIV_LAST = 16'(MOD_DIV - 1);
  localparam logic [15:0] HALF = 16'(MOD_DIV / 2);
  localparam logic [15:0] RATE_LAST = 16'(RATE_DIV - 1);
  localparam logic [15:0] SETTLE_W = 16'(SETTLE);

  typedef struct packed {
    logic [15:0] div;
    logic [15:0] wait_cnt;
    logic [15:0] pcnt;
    logic start;
    logic o;
    logic oe;
  } srl_gen_s;

  srl_gen_s s;
  srl_gen_s n;

  // =====================================================================
  // Pulse timing
  always_comb begin
    n = s;
    n.start = 1'b0;
    n.div = (s.div == DIV_LAST) ? 16'h0000 : 16'(s.div + 16'h0001);
    if (s.pcnt != 16'h0000) begin
      n.pcnt = 16'(s.pcnt - 16'h0001);
    end
    if (s.div == DIV_LAST) begin
      if (s.wait_cnt == 16'h0000) begin
        n.start = 1'b1;
        n.pcnt = HALF; // [R17]
        n.wait_cnt = RATE_LAST; // [R18]
      end else begin
        n.wait_cnt = 16'(s.wait_cnt - 16'h0001);
      end
    end
    // Reloading while held keeps the first pulse at settle plus delay after release.
    if (ifc.restart || !ifc.hw_active) begin
      n.div = 16'h0000;
      n.pcnt = 16'h0000;
      n.start = 1'b0;
      n.wait_cnt = 16'(SETTLE_W + {4'h0, ifc.phase_delay}); // [R18]
    end
    // Chip select never reaches this logic, so pulses run whatever chip select does. [R20]
    if (!ifc.hw_active) begin
      n.o = 1'b1; // [R21]
      n.oe = 1'b0;
    end else if (ifc.crc_flag || n.pcnt != 16'h0000) begin
      n.o = 1'b0; // [R22]
      n.oe = 1'b1;
    end else begin
      n.o = 1'b1;
      n.oe = ifc.float_sel; // [R19]
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
      s.wait_cnt <= SETTLE_W;
      s.o <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign ifc.ready_start = s.start;
  assign ifc.ready_o = s.o;
  assign ifc.ready_oe = s.oe;

  // =====================================================================
  // Checks
  property p_hw_quiet;
    @(posedge clk) disable iff (rst) !ifc.hw_active |=> !ifc.ready_oe && ifc.ready_o;
  endproperty
  a_hw_quiet: assert property (p_hw_quiet) else $error("ready pin active during hardware reset"); // [R21]

  property p_crc_low;
    @(posedge clk) disable iff (rst) (ifc.crc_flag && ifc.hw_active) |=> (!ifc.ready_o && ifc.ready_oe);
  endproperty
  a_crc_low: assert property (p_crc_low) else $error("ready pin not latched low on checksum flag"); // [R22]

  property p_idle_level;
    @(posedge clk) disable iff (rst)
      (ifc.hw_active && !ifc.crc_flag && n.pcnt == 16'h0000) |=> (ifc.ready_o && ifc.ready_oe == $past(ifc.float_sel));
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("idle ready level wrong"); // [R19]

  property p_pulse_low;
    @(posedge clk) disable iff (rst) (s.start && ifc.hw_active && !ifc.restart) |-> (!ifc.ready_o && ifc.ready_oe);
  endproperty
  a_pulse_low: assert property (p_pulse_low) else $error("ready pulse not driven low"); // [R17]

endmodule // srl_ready_gen

// ==== rtl/srl_top.sv ====
// Serial slave port with looping address pointer, write key and sample-ready output.
`timescale 1ns/100ps
module srl_top #(
  parameter logic [1:0] DEV_ID = srl_pkg::DEV_ID_DEF,
  parameter int MOD_DIV = 4,
  parameter int RATE_DIV = 256,
  parameter int SETTLE = 1024
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  input wire logic hw_reset_n,
  input wire logic config_checksum_flag,
  input wire logic result_valid,
  input wire logic [2:0] result_ch,
  input wire srl_pkg::srl_word_t result_data,
  output logic conv_restart,
  output logic [7:0] conv_restart_mask,
  output logic sample_ready_n_o,
  output logic sample_ready_n_oe
);
  import srl_pkg::*;

  typedef struct packed {
    srl_phase_e phase;
    logic sck_q;
    logic cpol;
    logic [4:0] cnt;
    logic [4:0] ptr;
    srl_word_t shift;
    srl_word_t shadow;
    logic sdo;
    logic sdo_oe;
    logic restart;
    logic [7:0] mask;
    logic [31:0][DATA_W-1:0] regs;
  } srl_state_s;

  srl_state_s s;
  srl_state_s n;
  srl_ready_if u_if ();

  logic sck_rise;
  logic sck_fall;
  logic word_end;
  logic locked;
  logic wr_ok;
  logic cfg_chg;
  logic ctrl_end;
  logic [7:0] ctrl;
  srl_word_t wdata;
  srl_word_t cfg_old;
  srl_loop_e rd_mode;
  srl_loop_e wr_mode;

  // =====================================================================
  // Decoding of the current state
  assign sck_rise = sck && !s.sck_q;
  assign sck_fall = !sck && s.sck_q;
  assign word_end = sck_rise && s.cnt == WORD_LAST;
  assign wdata = {s.shift[DATA_W-2:0], sdi}; // [R4]
  assign ctrl = {s.shift[6:0], sdi};
  assign locked = s.regs[ADDR_KEY][KEY_LSB +: 8] != KEY_UNLOCK;
  assign wr_ok = may_write(s.ptr, locked); // [R14]
  assign rd_mode = srl_loop_e'(s.regs[ADDR_STATUS][ST_READ_LSB +: 2]); // [R9]
  assign wr_mode = s.regs[ADDR_STATUS][ST_WRITE_BIT] ? SRL_LOOP_TYPE : SRL_LOOP_STATIC; // [R13]
  assign cfg_old = s.regs[ADDR_CONFIG];
  assign cfg_chg = (wdata[CF_OSR_LSB +: 3] != cfg_old[CF_OSR_LSB +: 3])
                || (wdata[CF_PRE_LSB +: 2] != cfg_old[CF_PRE_LSB +: 2])
                || (wdata[CF_EXTCLK_BIT] != cfg_old[CF_EXTCLK_BIT])
                || (wdata[CF_EXTREF_BIT] != cfg_old[CF_EXTREF_BIT]);

  // =====================================================================
  // Next state
  always_comb begin
    n = s;
    n.sck_q = sck;
    n.restart = 1'b0;
    if (result_valid) begin
      n.regs[{2'b00, result_ch}] = result_data;
    end
    // A clear that meets a new result in the same cycle wins, as the result is stale.
    if (s.restart) begin
      for (int i = 0; i < 8; i++) begin
        if (s.mask[i]) begin
          n.regs[i] = '0; // [R16]
        end
      end
    end
    if (cs_n) begin
      n.phase = SRL_PH_IDLE; // [R23]
      n.cnt = 5'h00;
      n.sdo_oe = 1'b0;
    end else begin
      case (s.phase)
        SRL_PH_IDLE: begin
          n.phase = SRL_PH_CTRL;
          n.cnt = 5'h00;
          n.cpol = sck;
          n.sdo_oe = 1'b0;
        end
        SRL_PH_CTRL: begin
          if (sck_rise) begin
            n.shift = wdata;
            n.cnt = 5'(s.cnt + 5'h01);
            if (s.cnt == CTRL_LAST) begin
              n.cnt = 5'h00;
              n.ptr = ctrl[5:1]; // [R1]
              if (ctrl[7:6] != DEV_ID) begin
                n.phase = SRL_PH_HOLD; // [R24]
              end else if (ctrl[0]) begin
                n.phase = SRL_PH_READ; // [R25]
                n.sdo_oe = 1'b1;
                n.shadow = s.regs[ctrl[5:1]];
                n.sdo = s.regs[ctrl[5:1]][DATA_W-1];
              end else begin
                n.phase = SRL_PH_WRITE; // [R7]
              end
            end
          end
        end
        SRL_PH_WRITE: begin
          n.sdo_oe = 1'b0; // [R3]
          if (sck_rise) begin
            n.shift = wdata;
            n.cnt = 5'(s.cnt + 5'h01);
            if (word_end) begin
              n.cnt = 5'h00;
              if (wr_ok) begin
                n.regs[s.ptr] = wdata; // [R1]
                n.ptr = next_ptr(s.ptr, wr_mode); // [R2] [R8]
                if (s.ptr == ADDR_PHASE0 || s.ptr == ADDR_PHASE1 || (s.ptr == ADDR_CONFIG && cfg_chg)) begin
                  n.restart = 1'b1; // [R15]
                  n.mask = ~(s.regs[ADDR_CHAN][CH_SOFT_LSB +: 8] | s.regs[ADDR_CHAN][CH_SHDN_LSB +: 8]);
                end
              end else begin
                n.phase = SRL_PH_HOLD; // [R5]
              end
            end
          end
        end
        SRL_PH_READ: begin
          // Serial input is not looked at here at all. [R10]
          if (sck_rise) begin
            n.cnt = 5'(s.cnt + 5'h01);
            if (word_end) begin
              n.cnt = 5'h00;
              n.ptr = next_ptr(s.ptr, rd_mode); // [R2] [R8]
            end
          end
          // An idle-high clock gives no falling edge after the last bit, so the LSB stays. [R12]
          if (sck_fall) begin
            if (s.cnt == 5'h00) begin
              n.shadow = s.regs[s.ptr];
              n.sdo = s.regs[s.ptr][DATA_W-1]; // [R11]
            end else begin
              n.sdo = s.shadow[WORD_LAST - s.cnt];
            end
          end else if (u_if.ready_start && !s.cpol && !sck && s.cnt == 5'h00) begin
            n.shadow = n.regs[s.ptr];
            n.sdo = n.regs[s.ptr][DATA_W-1]; // [R11]
          end
        end
        SRL_PH_HOLD: begin
          // Stalled or not addressed: wait for chip select to rise. [R6]
          n.sdo_oe = 1'b0;
        end
        default: begin
          n.phase = SRL_PH_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
      s.regs[ADDR_STATUS] <= STATUS_RST;
      s.regs[ADDR_KEY] <= KEY_RST;
    end else begin
      s <= n;
    end
  end

  // =====================================================================
  // Sample-ready generator
  assign u_if.restart = s.restart;
  assign u_if.float_sel = s.regs[ADDR_STATUS][ST_FLOAT_BIT];
  assign u_if.phase_delay = s.regs[ADDR_PHASE0][PH_DELAY_LSB +: PH_DELAY_W];
  assign u_if.crc_flag = config_checksum_flag;
  assign u_if.hw_active = hw_reset_n;

  srl_ready_gen #(
    .MOD_DIV(MOD_DIV),
    .RATE_DIV(RATE_DIV),
    .SETTLE(SETTLE)
  ) u_gen (
    .clk(clk),
    .rst(rst),
    .ifc(u_if.gen)
  );

  assign sdo = s.sdo;
  assign sdo_oe = s.sdo_oe;
  assign conv_restart = s.restart;
  assign conv_restart_mask = s.mask;
  assign sample_ready_n_o = u_if.ready_o;
  assign sample_ready_n_oe = u_if.ready_oe;

  // =====================================================================
  // Checks
  property p_write_hiz;
    @(posedge clk) disable iff (rst) (s.phase == SRL_PH_WRITE) |-> !sdo_oe;
  endproperty
  a_write_hiz: assert property (p_write_hiz) else $error("serial output driven during write"); // [R3]

  property p_cs_abort;
    @(posedge clk) disable iff (rst) cs_n |=> (s.phase == SRL_PH_IDLE && !sdo_oe && s.cnt == 5'h00);
  endproperty
  a_cs_abort: assert property (p_cs_abort) else $error("chip select rise did not abort"); // [R23]

  property p_stall;
    @(posedge clk) disable iff (rst)
      (!cs_n && s.phase == SRL_PH_WRITE && word_end && !wr_ok) |=> (s.phase == SRL_PH_HOLD && s.ptr == $past(s.ptr));
  endproperty
  a_stall: assert property (p_stall) else $error("non-writable write advanced pointer"); // [R5]

  property p_lock;
    @(posedge clk) disable iff (rst)
      (!cs_n && s.phase == SRL_PH_WRITE && word_end && locked && s.ptr != ADDR_KEY) |=> s.phase == SRL_PH_HOLD;
  endproperty
  a_lock: assert property (p_lock) else $error("locked map accepted a write"); // [R14]

  property p_store;
    @(posedge clk) disable iff (rst)
      (!cs_n && s.phase == SRL_PH_WRITE && word_end && wr_ok) |=> s.regs[$past(s.ptr)] == $past(wdata);
  endproperty
  a_store: assert property (p_store) else $error("written word not stored"); // [R1]

  property p_restart;
    @(posedge clk) disable iff (rst)
      (!cs_n && s.phase == SRL_PH_WRITE && word_end && wr_ok && s.ptr == ADDR_PHASE0) |=> conv_restart;
  endproperty
  a_restart: assert property (p_restart) else $error("phase write did not restart converters"); // [R15]

  property p_clear;
    @(posedge clk) disable iff (rst) (conv_restart && conv_restart_mask[0]) |=> s.regs[0] == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("result not cleared on restart"); // [R16]

  property p_wrap;
    @(posedge clk) disable iff (rst)
      (!cs_n && s.phase == SRL_PH_READ && word_end && s.ptr == set_last(s.ptr, rd_mode))
        |=> s.ptr == $past(set_first(s.ptr, rd_mode));
  endproperty
  a_wrap: assert property (p_wrap) else $error("pointer did not wrap to set start"); // [R8]

  assign ctrl_end = !cs_n && s.phase == SRL_PH_CTRL && sck_rise && s.cnt == CTRL_LAST;

  property p_id_ignore;
    @(posedge clk) disable iff (rst) (ctrl_end && ctrl[7:6] != DEV_ID) |=> s.phase == SRL_PH_HOLD;
  endproperty
  a_id_ignore: assert property (p_id_ignore) else $error("foreign identifier accepted"); // [R24]

  property p_dir;
    @(posedge clk) disable iff (rst)
      (ctrl_end && ctrl[7:6] == DEV_ID) |=> s.phase == ($past(ctrl[0]) ? SRL_PH_READ : SRL_PH_WRITE);
  endproperty
  a_dir: assert property (p_dir) else $error("direction bit not obeyed"); // [R25]

  property p_shift_in;
    @(posedge clk) disable iff (rst) (!cs_n && s.phase == SRL_PH_WRITE && sck_rise) |=> s.shift[0] == $past(sdi);
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("input bit not taken at rising clock"); // [R4]

  property p_read_ignore;
    @(posedge clk) disable iff (rst) (!cs_n && s.phase == SRL_PH_READ) |=> s.shift == $past(s.shift);
  endproperty
  a_read_ignore: assert property (p_read_ignore) else $error("input taken during read"); // [R10]

  property p_wr_static;
    @(posedge clk) disable iff (rst)
      (!cs_n && s.phase == SRL_PH_WRITE && word_end && wr_ok && wr_mode == SRL_LOOP_STATIC)
        |=> s.ptr == $past(s.ptr);
  endproperty
  a_wr_static: assert property (p_wr_static) else $error("static write loop moved the pointer"); // [R13]

  property p_rd_static;
    @(posedge clk) disable iff (rst)
      (!cs_n && s.phase == SRL_PH_READ && word_end && rd_mode == SRL_LOOP_STATIC) |=> s.ptr == $past(s.ptr);
  endproperty
  a_rd_static: assert property (p_rd_static) else $error("static read loop moved the pointer"); // [R9]

  property p_hold_lsb;
    @(posedge clk) disable iff (rst) (!cs_n && s.phase == SRL_PH_READ && s.cpol && !sck_fall) |=> $stable(sdo);
  endproperty
  a_hold_lsb: assert property (p_hold_lsb) else $error("output moved without a falling clock"); // [R12]

  property p_fall_msb;
    @(posedge clk) disable iff (rst)
      (!cs_n && s.phase == SRL_PH_READ && sck_fall && s.cnt == 5'h00) |=> sdo == $past(s.regs[s.ptr][DATA_W-1]);
  endproperty
  a_fall_msb: assert property (p_fall_msb) else $error("word start did not show the top bit"); // [R11]

endmodule // srl_top

// ==== testbench/srl_host_model.sv ====
// Host-side serial bus master model that drives whole frames into the port.
`timescale 1ns/100ps
module srl_host_model (
  input wire logic clk,
  input wire logic sdo,
  input wire logic sdo_oe,
  output logic cs_n,
  output logic sck,
  output logic sdi
);
  logic flip = 1'b0;
  logic sdo_w;
  // =====================================================================
  // Line model
  always @(posedge clk) flip <= ~flip;
  // A floating data line must never look like a stable value, so it toggles.
  assign sdo_w = sdo_oe ? sdo : flip;
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    sdi = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // =====================================================================
  // One control byte, then nbits-8 data bits; a short count aborts mid-word.
  task automatic frame(input bit cpol, input logic [7:0] ctrl, input int nbits, input logic [23:0] wd [8],
                       output logic [23:0] rd [8], output logic oe_seen, output logic tail);
    int w;
    oe_seen = 1'b0;
    for (int i = 0; i < 8; i++) rd[i] = 24'h00_0000;
    tick(1);
    sck = cpol;
    tick(4);
    cs_n = 1'b0;
    tick(2);
    for (int i = 0; i < nbits; i++) begin
      w = (i < 8) ? 0 : (i - 8) / 24;
      sck = 1'b0;
      if (i < 8) sdi = ctrl[7-i];
      else if (ctrl[0]) sdi = 1'($urandom);
      else sdi = wd[w][23-((i-8)%24)];
      tick(4);
      if (i >= 8) rd[w] = {rd[w][22:0], sdo_w};
      oe_seen = oe_seen | (sdo_oe & ~ctrl[0]);
      sck = 1'b1;
      tick(4);
    end
    tail = sdo_w;
    sck = cpol;
    tick(4);
    // Every frame is closed before the next control byte is sent.
    cs_n = 1'b1;
    tick(4);
  endtask
endmodule // srl_host_model

// ==== testbench/test_srl_top.sv ====
// Self-checking bench of the serial register loop block against a behavioural reference.
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin failures++; $display("BAD %0t got %h want %h", $time, (a), (b)); end end
module test_srl_top;
  import srl_pkg::*;
  logic clk, rst = 1'b1, hw_reset_n = 1'b0, config_checksum_flag = 1'b0, result_valid = 1'b0;
  logic [2:0] result_ch = 3'h0;
  srl_word_t result_data = 24'h00_0000;
  logic cs_n, sck, sdi, sdo, sdo_oe, conv_restart, rdy_o, rdy_oe, tail;
  logic [7:0] mask;
  logic [23:0] wd [8];
  logic [23:0] rd [8];
  logic oe_seen;
  int failures = 0, n_tests = 0, n_rst = 0;
  int regs [32];
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Long counts are shortened so a ready period is eight system clocks.
  srl_top #(.MOD_DIV(2), .RATE_DIV(4), .SETTLE(4)) u_srl_top (.clk(clk), .rst(rst), .cs_n(cs_n), .sck(sck),
    .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .hw_reset_n(hw_reset_n), .config_checksum_flag(config_checksum_flag),
    .result_valid(result_valid), .result_ch(result_ch), .result_data(result_data), .conv_restart(conv_restart),
    .conv_restart_mask(mask), .sample_ready_n_o(rdy_o), .sample_ready_n_oe(rdy_oe));
  srl_host_model host (.clk(clk), .sdo(sdo), .sdo_oe(sdo_oe), .cs_n(cs_n), .sck(sck), .sdi(sdi));
  always @(posedge clk) if (conv_restart === 1'b1) n_rst++;
  // =====================================================================
  // Reference model
  function automatic int nxt(input int a, input int m);
    int lo, hi;
    case (m)
      0: begin lo = a; hi = a; end
      1: begin lo = (a < 8) ? (a & 30) : 8; hi = (a < 8) ? lo + 1 : 31; end
      2: begin lo = (a < 8) ? 0 : 8; hi = (a < 8) ? 7 : 31; end
      default: begin lo = 0; hi = 31; end
    endcase
    return (a == hi) ? lo : a + 1;
  endfunction
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  task automatic wr(input bit cpol, input int a, input int nb, input logic [1:0] id = 2'h1);
    int p, er, r0, old;
    p = a;
    er = 0;
    r0 = n_rst;
    host.frame(cpol, {id, 5'(a), 1'b0}, nb, wd, rd, oe_seen, tail);
    for (int i = 0; i < (nb - 8) / 24 && id == 2'h1; i++) begin
      if (p < 8 || ((regs[31] & 255) != 'hA5 && p != 31)) break;
      old = regs[p];
      regs[p] = wd[i];
      if (p == 8 || p == 9 || (p == 11 && ((old ^ regs[p]) & 'h3_E0C0) != 0)) begin
        er++;
        for (int c = 0; c < 8; c++) if ((((regs[12] >> c) | (regs[12] >> (c + 8))) & 1) == 0) regs[c] = 0;
      end
      p = nxt(p, ((regs[10] >> 21) & 1) ? 2 : 0);
    end
    `CHK(oe_seen, 1'b0)
    `CHK(n_rst - r0, er)
    if (er > 0) `CHK(mask, 8'(~(regs[12] | (regs[12] >> 8))))
  endtask
  task automatic rdk(input bit cpol, input int a, input int n);
    int p;
    p = a;
    host.frame(cpol, {2'h1, 5'(a), 1'b1}, 8 + 24 * n, wd, rd, oe_seen, tail);
    for (int i = 0; i < n; i++) begin
      `CHK(rd[i], 24'(regs[p]))
      p = nxt(p, (regs[10] >> 22) & 3);
    end
    if (cpol) `CHK(tail, rd[n-1][0])
  endtask
  task automatic load(input int ch);
    result_ch = 3'(ch);
    result_data = 24'($urandom);
    result_valid = 1'b1;
    regs[ch] = result_data;
    @(posedge clk);
    #1;
  endtask
  task automatic rdy_win(input int len, input int lows, input int oes);
    int l, e;
    l = 0;
    e = 0;
    repeat (len) begin
      @(posedge clk);
      #1;
      l += (rdy_o === 1'b0);
      e += (rdy_oe === 1'b1);
    end
    #0;
    `CHK(l, lows)
    `CHK(e, oes)
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    #(40 * 60000);
    failures++;
    print_verdict();
  end
  // =====================================================================
  // Scenarios
  initial begin
    void'($urandom(14336));
    for (int i = 0; i < 32; i++) regs[i] = 0;
    regs[10] = 'hA0_0000;
    regs[31] = 'hA5;
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
    hw_reset_n = 1'b1;
    rdk(0, 10, 1);
    rdk(1, 31, 1);
    done("reset");
    for (int c = 0; c < 8; c++) load(c);
    result_valid = 1'b0;
    repeat (16) @(posedge clk); // Results are read only after the update delay.
    #1;
    wd[0] = 24'h00_0204;
    wr(1, 12, 32);
    wd[0] = 24'($urandom);
    wd[1] = 24'h00_00A5;
    wd[2] = 24'h00_0003;
    wr(0, 30, 80);
    rdk(1, 30, 3);
    rdk(0, 0, 8);
    wd[0] = 24'h00_0003;
    wr(1, 9, 32);
    done("restart");
    foreach (wd[i]) wd[i] = (i == 2) ? 24'h00_0040 : 24'h00_2000;
    for (int i = 0; i < 3; i++) begin
      wd[0] = wd[i];
      wr(i & 1, 11, 32);
    end
    done("config");
    for (int m = 0; m < 4; m++) begin
      wd[0] = 24'((m << 22) | (1 << 21));
      wr(0, 10, 32);
      rdk(m & 1, 7, 2);
      rdk(0, 31, 2);
    end
    done("read_loops");
    wd[0] = 24'h80_0000;
    wr(0, 10, 32);
    wd[0] = 24'($urandom);
    wd[1] = 24'($urandom);
    wr(1, 29, 56);
    rdk(0, 29, 1);
    wd[0] = 24'hA0_0000;
    wr(0, 10, 32);
    wr(0, 3, 80);
    wr(1, 13, 32);
    rdk(0, 3, 2);
    rdk(1, 13, 1);
    done("write_loops");
    wd[0] = 24'h00_0000;
    wr(0, 31, 32);
    wd[0] = 24'($urandom);
    wr(0, 20, 32);
    wr(1, 8, 32);
    wd[0] = 24'h00_00A5;
    wr(0, 31, 32);
    rdk(0, 20, 1);
    rdk(1, 8, 1);
    done("lock");
    wd[0] = 24'($urandom);
    wd[1] = 24'($urandom);
    wr(0, 20, 32, 2'h2);
    wr(1, 20, 20);
    wr(0, 20, 42);
    rdk(0, 20, 1);
    done("abort");
    rdy_win(64, 8, 8);
    wd[0] = 24'hB0_0000;
    wr(0, 10, 32);
    rdy_win(64, 8, 64);
    hw_reset_n = 1'b0;
    repeat (2) @(posedge clk);
    rdy_win(64, 0, 0);
    hw_reset_n = 1'b1;
    rdy_win(10, 0, 10);
    repeat (30) @(posedge clk);
    rdy_win(64, 8, 64);
    config_checksum_flag = 1'b1;
    repeat (2) @(posedge clk);
    rdy_win(64, 64, 64);
    done("ready_pin");
    print_verdict();
  end
endmodule // test_srl_top
